// file: ccpr_core_regs.sv
// Core pointer register set: accumulators, prefix, instruction and stack pointers, loop counters, frame and pointer control.
`timescale 1ns/10ps
`default_nettype none
module ccpr_core_regs #(
  parameter int ACC_COUNT = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [3:0] regModule,
  input wire logic [4:0] regIndex,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData_q,
  output logic regRdValid_q,
  // Accumulators and ALU.
  input wire logic [3:0] accumulatorSelector,
  input wire logic aluWrEn,
  input wire logic [15:0] aluResult,
  output logic [15:0] accOperand_q,
  // Prefix.
  output logic [7:0] prefixHighData_q,
  output logic prefixSrcBank_q,
  output logic [1:0] prefixDstBank_q,
  // Program flow.
  input wire logic fetch,
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic intAck,
  input wire logic djnzZero,
  input wire logic djnzOne,
  input wire logic [15:0] djnzTarget,
  output logic [15:0] nextFetchPointer_q,
  output logic [3:0] stackTopIndex_q,
  // Frame and data pointers.
  input wire logic [15:0] frameBase,
  input wire logic frameBaseWritten,
  input wire logic frameRead,
  input wire logic frameWrite,
  input wire ccpr_pkg::ccpr_step_type frameStep,
  input wire logic dpRead,
  input wire logic dpWrite,
  input wire logic dpSelect,
  input wire ccpr_pkg::ccpr_step_type dpStep,
  input wire logic dp0Written,
  input wire logic dp1Written,
  output logic [15:0] frameAddressSum_q,
  output ccpr_pkg::ccpr_step_type dp0Step_q,
  output ccpr_pkg::ccpr_step_type dp1Step_q,
  output logic [2:0] widthSelect_q,
  output logic [1:0] activeSource_q,
  output logic sourceValid_q
);
  import ccpr_pkg::*;

  if (ACC_COUNT < 1 || ACC_COUNT > 16) begin : gCheck
    $error("ACC_COUNT must lie between 1 and 16");
  end

  function automatic logic regHit(input logic [3:0] m, input logic [4:0] i,
                                  input logic [3:0] wm, input logic [4:0] wi);
    regHit = (m == wm) && (i == wi);
  endfunction

  function automatic logic [7:0] stepOffset(input logic [7:0] v, input ccpr_step_type s);
    stepOffset = (s == STEP_INC) ? 8'(v + 8'h01) : (s == STEP_DEC) ? 8'(v - 8'h01) : v;
  endfunction

  // Registers.
  logic [15:0] acc_q [ACC_COUNT];
  logic [15:0] pfx_q;
  logic [2:0] pfxIdx_q;
  logic [15:0] ip_q;
  logic [3:0] sp_q;
  logic [15:0] iv_q;
  logic [15:0] lc0_q;
  logic [15:0] lc1_q;
  logic [7:0] frame_offset_q;
  logic [DPC_BITS-1:0] dpc_q;
  logic srcValid_q;

  // Write decode.
  wire logic accRegWr = regWrEn && (regModule == MOD_ACC);
  wire logic pfxWr = regWrEn && (regModule == MOD_PFX);
  wire logic ipWr = regWrEn && regHit(regModule, regIndex, MOD_IP, IDX_IP);
  wire logic spWr = regWrEn && regHit(regModule, regIndex, MOD_SYS, IDX_SP);
  wire logic ivWr = regWrEn && regHit(regModule, regIndex, MOD_SYS, IDX_IV);
  wire logic lc0Wr = regWrEn && regHit(regModule, regIndex, MOD_SYS, IDX_LC0);
  wire logic lc1Wr = regWrEn && regHit(regModule, regIndex, MOD_SYS, IDX_LC1);
  wire logic offsWr = regWrEn && regHit(regModule, regIndex, MOD_FRAME, IDX_FRAME_OFFSET);
  wire logic dpcWr = regWrEn && regHit(regModule, regIndex, MOD_FRAME, IDX_DPC);

  // Accumulators.
  wire logic accSelOk = ({1'b0, accumulatorSelector} < 5'(ACC_COUNT));
  logic [15:0] accNext [ACC_COUNT];
  genvar g;
  for (g = 0; g < ACC_COUNT; g++) begin : gAcc
    wire logic regSel = accRegWr && (regIndex == 5'(g));
    wire logic aluSel = aluWrEn && (accumulatorSelector == 4'(g));
    assign accNext[g] = regSel ? regWrData : aluSel ? aluResult : acc_q[g];
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        acc_q[g] <= ACC_RST;
      else
        acc_q[g] <= accNext[g];
    end
  end
  // The operand is registered from the selected accumulator's next value, so it leaves a flip-flop yet does not lag the accumulator.
  wire logic [15:0] accOperandD = accSelOk ? accNext[accumulatorSelector] : 16'h0000;

  // Prefix: cleared every cycle unless written in that very cycle.
  wire logic [15:0] pfxD = pfxWr ? regWrData : PFX_RST;
  wire logic [2:0] pfxIdxD = pfxWr ? regIndex[2:0] : 3'h0;

  // Loop counters.
  wire logic [15:0] lc0Dec = 16'(lc0_q - 16'h0001);
  wire logic [15:0] lc1Dec = 16'(lc1_q - 16'h0001);
  wire logic [15:0] lc0D = lc0Wr ? regWrData : djnzZero ? lc0Dec : lc0_q;
  wire logic [15:0] lc1D = lc1Wr ? regWrData : djnzOne ? lc1Dec : lc1_q;
  wire logic djnzTake = (djnzZero && (lc0Dec != 16'h0000)) || (djnzOne && (lc1Dec != 16'h0000));

  // Instruction pointer: a write wins over every automatic change.
  wire logic [15:0] ipD = ipWr ? regWrData :
                          intAck ? iv_q :
                          djnzTake ? djnzTarget :
                          fetch ? 16'(ip_q + 16'h0001) : ip_q;

  // Stack pointer: an interrupt call pushes the return address as well.
  wire logic spUp = stackPush || intAck;
  wire logic [3:0] spD = spWr ? regWrData[3:0] :
                         (spUp && !stackPop) ? 4'(sp_q + 4'h1) :
                         (stackPop && !spUp) ? 4'(sp_q - 4'h1) : sp_q;

  wire logic [15:0] ivD = ivWr ? regWrData : iv_q;

  // Frame offset wraps inside eight bits; the base is an input and is never written here.
  wire ccpr_step_type frameReq = (frameRead || frameWrite) ? frameStep : STEP_NONE;
  wire logic [7:0] offsD = offsWr ? regWrData[7:0] : stepOffset(frame_offset_q, frameReq);
  wire logic [15:0] frameSumD = 16'(frameBase + {8'h00, offsD});

  // Data pointer steps for the pointer registers outside.
  wire logic dpAccess = dpRead || dpWrite;
  wire ccpr_step_type dp0StepD = (dpAccess && !dpSelect) ? dpStep : STEP_NONE;
  wire ccpr_step_type dp1StepD = (dpAccess && dpSelect) ? dpStep : STEP_NONE;

  // A change to a pointer marks it as the active source; a control write wins, then pointer zero, then pointer one, then the frame.
  wire logic dp0Mod = dp0Written || (dp0StepD != STEP_NONE);
  wire logic dp1Mod = dp1Written || (dp1StepD != STEP_NONE);
  wire logic frameMod = frameBaseWritten || offsWr || (frameReq != STEP_NONE);
  wire logic [1:0] sdpsD = dpcWr ? regWrData[DPC_SDPS_HI:DPC_SDPS_LO] :
                           dp0Mod ? SRC_DP0 : dp1Mod ? SRC_DP1 :
                           frameMod ? SRC_FRAME : dpc_q[DPC_SDPS_HI:DPC_SDPS_LO];
  wire logic [2:0] wbsD = dpcWr ? regWrData[DPC_WBS_FRAME:DPC_WBS_PTR0] : dpc_q[DPC_WBS_FRAME:DPC_WBS_PTR0];
  wire logic [DPC_BITS-1:0] dpcD = {wbsD, sdpsD};
  // The reset code is not yet a real selection; a control write or a change to any pointer makes it valid.
  wire logic srcValidD = srcValid_q || dpcWr || dp0Mod || dp1Mod || frameMod;
  wire logic [1:0] activeSrcD = sdpsD[1] ? SRC_FRAME : sdpsD;

  // Read multiplexer; unmapped locations read zero.
  wire logic accRdHit = (regModule == MOD_ACC) && ({1'b0, regIndex} < 6'(ACC_COUNT));
  wire logic [15:0] rdMux =
    accRdHit ? acc_q[regIndex[3:0]] :
    (regModule == MOD_PFX) ? pfx_q :
    regHit(regModule, regIndex, MOD_IP, IDX_IP) ? ip_q :
    regHit(regModule, regIndex, MOD_SYS, IDX_SP) ? {12'h000, sp_q} :
    regHit(regModule, regIndex, MOD_SYS, IDX_IV) ? iv_q :
    regHit(regModule, regIndex, MOD_SYS, IDX_LC0) ? lc0_q :
    regHit(regModule, regIndex, MOD_SYS, IDX_LC1) ? lc1_q :
    regHit(regModule, regIndex, MOD_FRAME, IDX_FRAME_OFFSET) ? {8'h00, frame_offset_q} :
    regHit(regModule, regIndex, MOD_FRAME, IDX_DPC) ? {11'h000, dpc_q} :
    regHit(regModule, regIndex, MOD_FRAME, IDX_FP) ? frameAddressSum_q : 16'h0000;
  wire logic [15:0] rdD = regRdEn ? rdMux : regRdData_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pfx_q <= PFX_RST;
      pfxIdx_q <= 3'h0;
      ip_q <= IP_RST;
      sp_q <= SP_RST;
      iv_q <= IV_RST;
      lc0_q <= LC_RST;
      lc1_q <= LC_RST;
      frame_offset_q <= FRAME_OFFSET_RST;
      dpc_q <= DPC_RST;
      srcValid_q <= 1'b0;
    end
    else
    begin
      pfx_q <= pfxD;
      pfxIdx_q <= pfxIdxD;
      ip_q <= ipD;
      sp_q <= spD;
      iv_q <= ivD;
      lc0_q <= lc0D;
      lc1_q <= lc1D;
      frame_offset_q <= offsD;
      dpc_q <= dpcD;
      srcValid_q <= srcValidD;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData_q <= 16'h0000;
      regRdValid_q <= 1'b0;
      accOperand_q <= 16'h0000;
      prefixHighData_q <= 8'h00;
      prefixSrcBank_q <= 1'b0;
      prefixDstBank_q <= 2'h0;
      frameAddressSum_q <= 16'h0000;
      dp0Step_q <= STEP_NONE;
      dp1Step_q <= STEP_NONE;
      widthSelect_q <= DPC_RST[DPC_WBS_FRAME:DPC_WBS_PTR0];
      activeSource_q <= SRC_DP0;
    end
    else
    begin
      regRdData_q <= rdD;
      regRdValid_q <= regRdEn;
      accOperand_q <= accOperandD;
      prefixHighData_q <= pfxD[7:0];
      prefixSrcBank_q <= pfxIdxD[0];
      prefixDstBank_q <= pfxIdxD[2:1];
      frameAddressSum_q <= frameSumD;
      dp0Step_q <= dp0StepD;
      dp1Step_q <= dp1StepD;
      widthSelect_q <= wbsD;
      activeSource_q <= activeSrcD;
    end
  end

  assign nextFetchPointer_q = ip_q;
  assign stackTopIndex_q = sp_q;
  assign sourceValid_q = srcValid_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_prefixWrite;
    pfxWr;
  endsequence

  sequence s_prefixHoldThenClear;
    ##1 (pfx_q == $past(regWrData)) ##1 ($past(pfxWr) || (pfx_q == 16'h0000));
  endsequence

  a_prefix_one_cycle: assert property (s_prefixWrite |-> s_prefixHoldThenClear)
    else $error("prefix value did not last exactly one cycle");

  a_prefix_bank_select: assert property (pfxWr |=> (prefixSrcBank_q == $past(regIndex[0])) &&
                                         (prefixDstBank_q == $past(regIndex[2:1])))
    else $error("prefix bank selection does not follow the write index");

  a_prefix_default_clear: assert property (!pfxWr |=> (pfxIdx_q == 3'h0) && (pfx_q == 16'h0000) &&
                                           (prefixHighData_q == 8'h00))
    else $error("prefix did not return to default");

  a_fetch_advance: assert property (fetch && !ipWr && !intAck && !djnzTake |=>
                                    nextFetchPointer_q == 16'($past(ip_q) + 16'h0001))
    else $error("instruction pointer did not advance by one");

  a_ip_jump_write: assert property (ipWr |=> nextFetchPointer_q == $past(regWrData))
    else $error("instruction pointer write did not redirect");

  a_stack_push_pop: assert property (!spWr && (spUp != stackPop) |=>
                                     stackTopIndex_q == ($past(spUp) ? 4'($past(sp_q) + 4'h1) :
                                                         4'($past(sp_q) - 4'h1)))
    else $error("stack pointer step wrong");

  a_int_vector_call: assert property (intAck && !ipWr |=> nextFetchPointer_q == $past(iv_q))
    else $error("interrupt did not call the vector");

  a_loop_decrement: assert property (djnzZero && !lc0Wr |=> lc0_q == 16'($past(lc0_q) - 16'h0001))
    else $error("loop counter zero did not decrement");

  a_frame_sum: assert property (##1 frameAddressSum_q == 16'($past(frameBase) + {8'h00, frame_offset_q}))
    else $error("frame address is not base plus offset");

  a_control_reserved: assert property (regRdEn && regHit(regModule, regIndex, MOD_FRAME, IDX_DPC) |=>
                                       regRdData_q[15:5] == 11'h000)
    else $error("pointer control upper bits not zero");

  a_source_follows_ptr: assert property (dp0Written && !dpcWr |=>
                                         (activeSource_q == SRC_DP0) && sourceValid_q)
    else $error("pointer zero write did not make it the active source");

  a_loop_one_decrement: assert property (djnzOne && !lc1Wr |=> lc1_q == 16'($past(lc1_q) - 16'h0001))
    else $error("loop counter one did not decrement");

  a_push_pop_cancel: assert property (!spWr && spUp && stackPop |=> stackTopIndex_q == $past(sp_q))
    else $error("push and pop together moved the stack pointer");

  a_offset_step_up: assert property (!offsWr && (frameReq == STEP_INC) |=> frame_offset_q == 8'($past(frame_offset_q) + 8'h01))
    else $error("frame offset did not step up");

  a_offset_step_down: assert property (!offsWr && (frameReq == STEP_DEC) |=> frame_offset_q == 8'($past(frame_offset_q) - 8'h01))
    else $error("frame offset did not step down");

  a_source_valid_hold: assert property (sourceValid_q |=> sourceValid_q)
    else $error("active source selection was lost");

  a_source_reserved_code: assert property (dpcWr && (regWrData[1:0] == 2'h3) |=> activeSource_q == SRC_FRAME)
    else $error("reserved source code did not pick the frame pointer");

  a_width_write: assert property (dpcWr |=> widthSelect_q == $past(regWrData[4:2]))
    else $error("width select does not follow the control write");

  a_alu_result_write: assert property (aluWrEn && accSelOk && !accRegWr |=> accOperand_q == $past(aluResult))
    else $error("selected accumulator did not take the ALU result");

  a_ptr_step_command: assert property (dpAccess && dpSelect |=> dp1Step_q == $past(dpStep))
    else $error("pointer one step command wrong");

  a_prefix_high_byte: assert property (pfxWr |=> prefixHighData_q == $past(regWrData[7:0]))
    else $error("prefix high data is not the written low byte");

endmodule // ccpr_core_regs
`default_nettype wire

// file: ccpr_core_regs_test.sv
// Self-checking testbench for the core pointer register set.
`timescale 1ns/10ps
`default_nettype none
module ccpr_core_regs_test;
  import ccpr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic regWrEn, regRdEn, aluGo, fetch, stackPush, stackPop, intAck, djnzZero, djnzOne, baseLoad;
  logic frameRead, frameWrite, dpRead, dpWrite, dpSelect, dp0Written, dp1Written;
  logic [3:0] regModule, accumulatorSelector, stackTopIndex_q;
  logic [4:0] regIndex;
  logic [15:0] regWrData, djnzTarget, baseValue, regRdData_q, accOperand_q, nextFetchPointer_q;
  logic [15:0] frameAddressSum_q, frameBase, aluResult, v;
  logic regRdValid_q, prefixSrcBank_q, sourceValid_q, aluWrEn, frameBaseWritten;
  logic [7:0] prefixHighData_q;
  logic [1:0] prefixDstBank_q, activeSource_q;
  logic [2:0] widthSelect_q;
  ccpr_step_type frameStep, dpStep, dp0Step_q, dp1Step_q;
  logic [31:0] lfsrState = 32'h7223;
  int errTotal = 0;
  int samplesChecked = 0;

  ccpr_core_regs dut_u (.clk, .rstn, .regWrEn, .regRdEn, .regModule, .regIndex, .regWrData, .regRdData_q,
    .regRdValid_q, .accumulatorSelector, .aluWrEn, .aluResult, .accOperand_q, .prefixHighData_q,
    .prefixSrcBank_q, .prefixDstBank_q, .fetch, .stackPush, .stackPop, .intAck, .djnzZero, .djnzOne,
    .djnzTarget, .nextFetchPointer_q, .stackTopIndex_q, .frameBase, .frameBaseWritten, .frameRead,
    .frameWrite, .frameStep, .dpRead, .dpWrite, .dpSelect, .dpStep, .dp0Written, .dp1Written,
    .frameAddressSum_q, .dp0Step_q, .dp1Step_q, .widthSelect_q, .activeSource_q, .sourceValid_q);
  ccpr_partner_model partner_u (.clk, .rstn, .aluGo, .baseLoad, .baseValue, .accOperand(accOperand_q),
    .aluWrEn, .aluResult, .frameBase_q(frameBase), .frameBaseWritten_q(frameBaseWritten));

  initial
  begin
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] srcExp(input logic [1:0] c);
    return (c == 2'h3) ? 16'h0002 : {14'h0, c};
  endfunction

  task automatic testDone;
    $display("checks made %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  task automatic rnd(output logic [15:0] r);
    repeat (16) lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    r = lfsrState[15:0];
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d);
    {regWrEn, regModule, regIndex, regWrData} = {1'b1, m, i, d};
    tick();
    regWrEn = 1'b0;
  endtask

  // Reads are taken at one edge and answered with a one-cycle valid at that same edge.
  task automatic rdChk(input string what, input logic [3:0] m, input logic [4:0] i, input logic [15:0] exp);
    {regRdEn, regModule, regIndex} = {1'b1, m, i};
    tick();
    regRdEn = 1'b0;
    chk("read valid", 16'h0001, {15'h0, regRdValid_q});
    chk(what, exp, regRdData_q);
    tick();
  endtask

  initial
  begin
    #20000;
    errTotal++;
    testDone();
  end

  initial
  begin
    {regWrEn, regRdEn, aluGo, fetch, stackPush, stackPop, intAck, djnzZero, djnzOne, baseLoad} = '0;
    {frameRead, frameWrite, dpRead, dpWrite, dpSelect, dp0Written, dp1Written} = '0;
    {regModule, regIndex, regWrData, djnzTarget, baseValue, accumulatorSelector} = '0;
    frameStep = STEP_NONE;
    dpStep = STEP_NONE;
    tick(2);
    rstn = 1'b1;
    chk("source valid", 16'h0000, {15'h0, sourceValid_q});
    chk("width", 16'h0007, {13'h0, widthSelect_q});
    rdChk("ip", MOD_IP, IDX_IP, 16'h8000);
    rdChk("sp", MOD_SYS, IDX_SP, 16'h000f);
    rdChk("dpc", MOD_FRAME, IDX_DPC, 16'h001c);
    rdChk("iv", MOD_SYS, IDX_IV, 16'h0000);
    rdChk("lc0", MOD_SYS, IDX_LC0, 16'h0000);
    rdChk("frame_offset", MOD_FRAME, IDX_FRAME_OFFSET, 16'h0000);
    pulse(dp0Written);
    chk("source valid", 16'h0001, {15'h0, sourceValid_q});
    chk("source", 16'h0000, {14'h0, activeSource_q});
    $display("test reset done");
    for (int n = 0; n < 16; n++)
    begin
      rdChk("acc reset", MOD_ACC, n[4:0], 16'h0000);
      rnd(v);
      wr(MOD_ACC, n[4:0], v);
      rdChk("acc", MOD_ACC, n[4:0], v);
    end
    accumulatorSelector = 4'hf;
    tick(2);
    chk("operand", v, accOperand_q);
    pulse(aluGo);
    tick(2);
    chk("alu result", v + 16'h0101, accOperand_q);
    rdChk("acc alu", MOD_ACC, 5'h0f, v + 16'h0101);
    $display("test accumulators done");
    for (int i = 0; i < 8; i++)
    begin
      rnd(v);
      wr(MOD_PFX, i[4:0], v);
      chk("prefix data", {8'h0, v[7:0]}, {8'h0, prefixHighData_q});
      chk("prefix banks", {13'h0, i[2:0]}, {13'h0, prefixDstBank_q, prefixSrcBank_q});
      rdChk("prefix shared", MOD_PFX, 5'h1f - i[4:0], v);
      chk("prefix clear", 16'h0, {5'h0, prefixHighData_q, prefixDstBank_q, prefixSrcBank_q});
    end
    rdChk("prefix idle", MOD_PFX, 5'h02, 16'h0000);
    $display("test prefix done");
    fetch = 1'b1;
    tick(3);
    fetch = 1'b0;
    chk("ip fetch", 16'h8003, nextFetchPointer_q);
    rdChk("ip", MOD_IP, IDX_IP, 16'h8003);
    chk("ip kept", 16'h8003, nextFetchPointer_q);
    rnd(v);
    wr(MOD_IP, IDX_IP, v);
    chk("ip jump", v, nextFetchPointer_q);
    pulse(fetch);
    chk("ip step", v + 16'h0001, nextFetchPointer_q);
    pulse(stackPush);
    chk("sp push", 16'h0000, {12'h0, stackTopIndex_q});
    pulse(stackPop);
    chk("sp pop", 16'h000f, {12'h0, stackTopIndex_q});
    wr(MOD_SYS, IDX_SP, 16'hfff5);
    rdChk("sp", MOD_SYS, IDX_SP, 16'h0005);
    rnd(v);
    wr(MOD_SYS, IDX_IV, v);
    pulse(intAck);
    chk("call", v, nextFetchPointer_q);
    chk("call push", 16'h0006, {12'h0, stackTopIndex_q});
    wr(MOD_SYS, IDX_LC0, 16'h0002);
    rnd(v);
    djnzTarget = ~v;
    pulse(djnzZero);
    chk("loop jump", ~v, nextFetchPointer_q);
    rdChk("lc0", MOD_SYS, IDX_LC0, 16'h0001);
    wr(MOD_SYS, IDX_LC1, 16'h0001);
    djnzTarget = v;
    pulse(djnzOne);
    chk("loop end", ~v, nextFetchPointer_q);
    rdChk("lc1", MOD_SYS, IDX_LC1, 16'h0000);
    $display("test flow done");
    for (int c = 0; c < 4; c++)
    begin
      rnd(v);
      wr(MOD_FRAME, IDX_DPC, {v[15:2], c[1:0]});
      rdChk("dpc", MOD_FRAME, IDX_DPC, {11'h0, v[4:2], c[1:0]});
      chk("width", {13'h0, v[4:2]}, {13'h0, widthSelect_q});
      chk("source", srcExp(c[1:0]), {14'h0, activeSource_q});
    end
    pulse(dp1Written);
    chk("source", 16'h0001, {14'h0, activeSource_q});
    dpSelect = 1'b1;
    dpStep = STEP_INC;
    pulse(dpRead);
    chk("dp1 step", {14'h0, STEP_INC}, {14'h0, dp1Step_q});
    chk("dp0 step", {14'h0, STEP_NONE}, {14'h0, dp0Step_q});
    dpSelect = 1'b0;
    dpStep = STEP_DEC;
    pulse(dpWrite);
    chk("dp0 step", {14'h0, STEP_DEC}, {14'h0, dp0Step_q});
    $display("test pointer control done");
    rnd(v);
    baseValue = v;
    pulse(baseLoad);
    tick(2);
    chk("source", 16'h0002, {14'h0, activeSource_q});
    wr(MOD_FRAME, IDX_FRAME_OFFSET, 16'h12ff);
    rdChk("frame_offset", MOD_FRAME, IDX_FRAME_OFFSET, 16'h00ff);
    chk("frame sum", v + 16'h00ff, frameAddressSum_q);
    rdChk("frame read", MOD_FRAME, IDX_FP, v + 16'h00ff);
    frameStep = STEP_INC;
    pulse(frameRead);
    frameStep = STEP_DEC;
    tick(2);
    chk("offset wrap", v, frameAddressSum_q);
    pulse(frameWrite);
    frameStep = STEP_NONE;
    tick(2);
    chk("offset borrow", v + 16'h00ff, frameAddressSum_q);
    rdChk("frame_offset", MOD_FRAME, IDX_FRAME_OFFSET, 16'h00ff);
    $display("test frame done");
    testDone();
  end
endmodule // ccpr_core_regs_test
`default_nettype wire

// file: ccpr_partner_model.sv
// Model of the decoder and ALU side that drives the core pointer register set.
`timescale 1ns/10ps
`default_nettype none
module ccpr_partner_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Commands from the bench.
  input wire logic aluGo,
  input wire logic baseLoad,
  input wire logic [15:0] baseValue,
  // Core side.
  input wire logic [15:0] accOperand,
  output logic aluWrEn,
  output logic [15:0] aluResult,
  output logic [15:0] frameBase_q,
  output logic frameBaseWritten_q
);
  // The ALU adds a fixed step, so a stale operand shows up as a wrong sum.
  assign aluWrEn = aluGo;
  assign aluResult = accOperand + 16'h0101;
  // The base register lives here; its write pulse comes with the new value.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameBase_q <= 16'h0000;
      frameBaseWritten_q <= 1'b0;
    end
    else
    begin
      frameBaseWritten_q <= baseLoad;
      if (baseLoad)
        frameBase_q <= baseValue;
    end
  end
endmodule // ccpr_partner_model
`default_nettype wire

// file: ccpr_pkg.sv
// Constants and types shared by the core pointer register set.
`default_nettype none
package ccpr_pkg;
  // Register modules.
  localparam logic [3:0] MOD_ACC = 4'h9;
  localparam logic [3:0] MOD_PFX = 4'hb;
  localparam logic [3:0] MOD_IP = 4'hc;
  localparam logic [3:0] MOD_SYS = 4'hd;
  localparam logic [3:0] MOD_FRAME = 4'he;
  // Register indexes.
  localparam logic [4:0] IDX_IP = 5'h00;
  localparam logic [4:0] IDX_SP = 5'h01;
  localparam logic [4:0] IDX_IV = 5'h02;
  localparam logic [4:0] IDX_LC0 = 5'h06;
  localparam logic [4:0] IDX_LC1 = 5'h07;
  localparam logic [4:0] IDX_FRAME_OFFSET = 5'h03;
  localparam logic [4:0] IDX_DPC = 5'h04;
  localparam logic [4:0] IDX_FP = 5'h0b;
  // Reset values.
  localparam logic [15:0] ACC_RST = 16'h0000;
  localparam logic [15:0] PFX_RST = 16'h0000;
  localparam logic [15:0] IP_RST = 16'h8000;
  localparam logic [3:0] SP_RST = 4'hf;
  localparam logic [15:0] IV_RST = 16'h0000;
  localparam logic [15:0] LC_RST = 16'h0000;
  localparam logic [7:0] FRAME_OFFSET_RST = 8'h00;
  localparam logic [4:0] DPC_RST = 5'h1c;
  // Pointer control field positions.
  localparam int DPC_WBS_FRAME = 4;
  localparam int DPC_WBS_PTR1 = 3;
  localparam int DPC_WBS_PTR0 = 2;
  localparam int DPC_SDPS_HI = 1;
  localparam int DPC_SDPS_LO = 0;
  localparam int DPC_BITS = 5;
  // Source pointer codes.
  localparam logic [1:0] SRC_DP0 = 2'h0;
  localparam logic [1:0] SRC_DP1 = 2'h1;
  localparam logic [1:0] SRC_FRAME = 2'h2;
  // Pointer step requests.
  typedef enum logic [1:0] {
    STEP_NONE = 2'h0,
    STEP_INC = 2'h1,
    STEP_DEC = 2'h2
  } ccpr_step_type;
endpackage
`default_nettype wire
